// ---- logic/smc_map.svh ----
// smc_map.svh: offsets, field positions, reset values and timing counts
// of the sleep and interrupt 0 controller; definitions only.
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
// register index as printed, byte address is four times it
`define SMC_GENCTL_IDX 8'h35
`define SMC_GENCTL_ADDR 10'h0d4
`define SMC_STAT_ADDR 10'h0d8
`define SMC_GENCTL_RST 8'h00
`define SMC_GENCTL_WMASK 8'h7b
`define SMC_BIT_PUD 6
`define SMC_BIT_ARM 5
`define SMC_SEL_HI 4
`define SMC_SEL_LO 3
`define SMC_SNS_HI 1
`define SMC_SNS_LO 0
// wake timing, in cycles of clk_sys
`define SMC_STANDBY_WAKE 8'h06
`define SMC_IRQ_STALL 8'h04
`define SMC_SU_UNIT 8'h10
`endif

// ---- logic/smc_pkg.sv ----
// smc_pkg.sv: types shared by the sleep controller files.
// assumes smc_map.svh is included where offsets are needed.
package smc_pkg;
   typedef enum logic [1:0] {
      SMC_IDLE = 2'h0,
      SMC_ADCNR = 2'h1,
      SMC_PDOWN = 2'h2,
      SMC_STBY = 2'h3
   } smc_mode_t;

   typedef enum logic [1:0] {
      SMC_LOW = 2'h0,
      SMC_ANY = 2'h1,
      SMC_FALL = 2'h2,
      SMC_RISE = 2'h3
   } smc_sense_t;

   // clock domain enables; high means the domain runs
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic osc;
   } smc_clk_t;

   // wake-up sources from the rest of the chip, all same-clock levels
   typedef struct packed {
      logic adc_done;
      logic usi_start;
      logic ee_ready;
      logic pin_change;
      logic other_io;
   } smc_wake_t;
endpackage

// ---- logic/smc_ext_irq0_pin.sv ----
// smc_ext_irq0_pin.sv: external interrupt 0 sensing.
// assumes the pin is asynchronous; it is synchronised here.
`timescale 1ns/100ps
`default_nettype none
module smc_ext_irq0_pin (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin,
   input wire smc_pkg::smc_sense_t sense,
   input wire logic enable,
   output logic level_low,
   output logic request
);
   logic s1_q;
   logic s2_q;
   logic prev_q;
   logic hit;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         prev_q <= s2_q;
      end
   end

   always_comb begin
      case (sense)
         smc_pkg::SMC_LOW: hit = !s2_q;
         smc_pkg::SMC_ANY: hit = s2_q != prev_q;
         smc_pkg::SMC_FALL: hit = prev_q && !s2_q;
         default: hit = !prev_q && s2_q;
      endcase
   end

   assign level_low = !s2_q && (sense == smc_pkg::SMC_LOW);
   assign request = hit && enable;
endmodule
`default_nettype wire

// ---- logic/smc_ctrl.sv ----
// smc_ctrl.sv: general control register, sleep state machine, clock
// gating, wake-up qualification and interrupt 0 request.
// assumes a classic Wishbone master on clk_sys and same-clock wake sources.
`include "smc_map.svh"
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: pullup_disable kills every port pull-up
// R2: sleep entered only when sleep_arm set
// R3: software sets sleep_arm just before sleeping
// R4: sleep_select picks idle, adcnr, power-down, standby
// R5: ext_irq0_pin needs global flag and mask
// R6: ext_irq0_pin_sense selects level, change, fall, rise
// R7: software masks ext_irq0_pin before changing sense
// R8: idle stops only cpu and flash clocks
// R9: idle wakes on external and internal interrupts
// R10: idle or adcnr starts ADC conversion
// R11: adcnr stops io, cpu and flash clocks
// R12: adcnr wakes on listed sources only
// R13: power-down stops oscillator and all clocks
// R14: power-down/standby wake: reset, usi, level, pinchange
// R15: power-down wake waits startup_select period
// R16: vanished level wake skips the interrupt; the code drops only a vanished pin-change wake
// R17: standby keeps oscillator, wakes in six cycles
// R18: eeprom and ADC wake only idle/adcnr
// R19: stall four cycles then run handler
// R20: reset during sleep restarts at reset vector
// R21: unarmed sleep acts as no-operation
module smc_ctrl (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic sleep_instr,
   input wire logic global_irq_en,
   input wire logic ext_irq0_pin_mask,
   input wire logic ext_irq0_pin,
   input wire logic adc_enabled,
   input wire logic ext_crystal,
   input wire logic [3:0] startup_select,
   input wire smc_pkg::smc_wake_t wake_src,
   input wire logic [7:0] pin_direction,
   input wire logic [7:0] pin_output_value,
   output logic [7:0] pullup_en,
   output smc_pkg::smc_clk_t clk_en,
   output logic cpu_stall,
   output logic sleep_done,
   output logic adc_start,
   output logic ext_irq0_pin_irq,
   output logic wake_irq_drop
);
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [7:0] gen_q;
   logic ack_q;
   logic req;
   logic hit_gen;
   logic hit_stat;

   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_SLEEP = 5'h02,
      ST_WAKE = 5'h04,
      ST_STALL = 5'h08,
      ST_NOP = 5'h10
   } smc_state_t;

   smc_state_t state_q;
   smc_pkg::smc_mode_t mode_q;
   logic drop_q;

   // ack_q masks the request so a held cycle is answered every other clock, not every clock
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign hit_gen = wb_adr_i == `SMC_GENCTL_ADDR;
   assign hit_stat = wb_adr_i == `SMC_STAT_ADDR;
   // unmapped addresses answer with err instead of ack
   assign wb_ack_o = ack_q && (hit_gen || hit_stat);
   assign wb_err_o = ack_q && !(hit_gen || hit_stat);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // write takes effect at the acking edge; reserved bits 7 and 2 stay zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gen_q <= `SMC_GENCTL_RST;
      end else if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i && hit_gen && wb_sel_i[0]) begin
         gen_q <= wb_dat_i[7:0] & `SMC_GENCTL_WMASK;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0;
      end else if (req) begin
         if (hit_gen) begin
            wb_dat_o <= {24'h0, gen_q};
         end else if (hit_stat) begin
            wb_dat_o <= {24'h0, 1'b0, drop_q, mode_q, 1'b0, state_q == ST_SLEEP,
               state_q == ST_WAKE, state_q == ST_STALL};
         end else begin
            wb_dat_o <= 32'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // pull-ups and interrupt 0
   // ----------------------------------------------------------------
   logic ext_irq0_pin_level;
   logic ext_irq0_pin_req;

   assign pullup_en = gen_q[`SMC_BIT_PUD] ? 8'h00 : (~pin_direction & pin_output_value); // R1

   smc_ext_irq0_pin u_ext_irq0_pin (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(ext_irq0_pin),
      .sense(smc_pkg::smc_sense_t'(gen_q[`SMC_SNS_HI:`SMC_SNS_LO])), // R6
      .enable(global_irq_en && ext_irq0_pin_mask), // R5
      .level_low(ext_irq0_pin_level),
      .request(ext_irq0_pin_req)
   );

   // ----------------------------------------------------------------
   // wake qualification
   // ----------------------------------------------------------------
   function automatic logic wake_ok(input smc_pkg::smc_mode_t m, input smc_pkg::smc_wake_t w,
         input logic ext_any, input logic lvl);
      logic r;
      r = 1'b0;
      case (m)
         smc_pkg::SMC_IDLE: r = ext_any || w.usi_start || w.ee_ready || w.adc_done
            || w.pin_change || w.other_io; // R9
         smc_pkg::SMC_ADCNR: r = w.adc_done || w.usi_start || w.ee_ready || lvl
            || w.pin_change; // R12 R18
         default: r = w.usi_start || lvl || w.pin_change; // R14
      endcase
      return r;
   endfunction

   logic wake_now;
   logic lvl_irq;
   assign lvl_irq = ext_irq0_pin_level && global_irq_en && ext_irq0_pin_mask;
   assign wake_now = wake_ok(mode_q, wake_src, ext_irq0_pin_req, lvl_irq);

   // ----------------------------------------------------------------
   // sleep state machine
   // ----------------------------------------------------------------
   logic [7:0] cnt_q;
   logic lvl_cause_q;
   logic [7:0] wake_len;
   logic cond_live;

   // start-up counts scale with startup_select; standby with ext_crystal takes six
   always_comb begin
      if (mode_q == smc_pkg::SMC_STBY && ext_crystal) begin
         wake_len = `SMC_STANDBY_WAKE; // R17
      end else if (mode_q == smc_pkg::SMC_PDOWN || mode_q == smc_pkg::SMC_STBY) begin
         wake_len = 8'({4'h0, startup_select} * `SMC_SU_UNIT) + 8'h01; // R15
      end else begin
         wake_len = 8'h01;
      end
   end

   assign cond_live = lvl_irq || wake_src.pin_change;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN; // R20
         mode_q <= smc_pkg::SMC_IDLE;
         cnt_q <= 8'h00;
         lvl_cause_q <= 1'b0;
         drop_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (sleep_instr && gen_q[`SMC_BIT_ARM]) begin // R2
                  mode_q <= smc_pkg::smc_mode_t'(gen_q[`SMC_SEL_HI:`SMC_SEL_LO]); // R4
                  state_q <= ST_SLEEP;
               end else if (sleep_instr) begin
                  state_q <= ST_NOP; // R21
               end
            end
            ST_NOP: begin
               state_q <= ST_RUN;
            end
            ST_SLEEP: begin
               if (wake_now) begin
                  // only a pure pin-change wake may later be dropped, as a level wake also raises ext_irq0_pin_req;
                  // an edge or event cause is latched and always served
                  lvl_cause_q <= !(wake_src.usi_start || wake_src.adc_done
                     || wake_src.ee_ready || wake_src.other_io || ext_irq0_pin_req) && cond_live;
                  cnt_q <= wake_len;
                  drop_q <= 1'b0;
                  state_q <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (cnt_q <= 8'h01) begin
                  // a pin-change cause that vanished is dropped
                  if (lvl_cause_q && !cond_live) begin
                     drop_q <= 1'b1; // R16
                  end
                  cnt_q <= `SMC_IRQ_STALL;
                  state_q <= ST_STALL;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               if (cnt_q <= 8'h01) begin
                  state_q <= ST_RUN; // R19
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // clock gating and outputs
   // ----------------------------------------------------------------
   logic asleep;
   assign asleep = state_q == ST_SLEEP || state_q == ST_WAKE;

   always_comb begin
      clk_en = '1;
      if (asleep) begin
         clk_en.cpu = 1'b0; // R8
         clk_en.flash = 1'b0;
         case (mode_q)
            smc_pkg::SMC_IDLE: clk_en.io = 1'b1;
            smc_pkg::SMC_ADCNR: clk_en.io = 1'b0; // R11
            smc_pkg::SMC_PDOWN: begin
               clk_en.io = 1'b0; // R13
               clk_en.adc = 1'b0;
               clk_en.osc = state_q == ST_WAKE;
            end
            default: begin
               clk_en.io = 1'b0;
               clk_en.adc = 1'b0;
               clk_en.osc = ext_crystal || state_q == ST_WAKE; // R17
            end
         endcase
      end
   end

   assign cpu_stall = state_q != ST_RUN;
   assign sleep_done = state_q == ST_NOP;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         adc_start <= 1'b0;
         ext_irq0_pin_irq <= 1'b0;
         wake_irq_drop <= 1'b0;
      end else begin
         adc_start <= state_q == ST_RUN && sleep_instr && gen_q[`SMC_BIT_ARM] && adc_enabled
            && !gen_q[`SMC_SEL_HI]; // R10
         ext_irq0_pin_irq <= ext_irq0_pin_req && !(state_q == ST_STALL && drop_q); // R16
         wake_irq_drop <= drop_q && state_q == ST_STALL;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_PUD_OFF: assert property (@(posedge clk_sys) disable iff (rst) // R1
      gen_q[`SMC_BIT_PUD] |-> pullup_en == 8'h00) else $error("pull-up on while disabled");
   AST_NO_ARM: assert property (@(posedge clk_sys) disable iff (rst) // R21
      state_q == ST_RUN && sleep_instr && !gen_q[`SMC_BIT_ARM] |=> state_q == ST_NOP ##1
      state_q == ST_RUN) else $error("unarmed sleep did not pass");
   AST_ARM_SLEEP: assert property (@(posedge clk_sys) disable iff (rst) // R2
      state_q == ST_RUN && sleep_instr && gen_q[`SMC_BIT_ARM] |=> state_q == ST_SLEEP)
      else $error("armed sleep not entered");
   AST_IDLE_CLK: assert property (@(posedge clk_sys) disable iff (rst) // R8
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_IDLE |-> !clk_en.cpu && !clk_en.flash
      && clk_en.io && clk_en.adc) else $error("idle clocks wrong");
   AST_NR_CLK: assert property (@(posedge clk_sys) disable iff (rst) // R11
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_ADCNR |-> !clk_en.io && clk_en.adc)
      else $error("noise reduction clocks wrong");
   AST_PD_CLK: assert property (@(posedge clk_sys) disable iff (rst) // R13
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_PDOWN |-> !clk_en.osc && !clk_en.adc)
      else $error("power-down clocks running");
   AST_PD_EDGE: assert property (@(posedge clk_sys) disable iff (rst) // R14
      state_q == ST_SLEEP && mode_q[1] && !wake_src.usi_start && !wake_src.pin_change
      && !lvl_irq |=> state_q == ST_SLEEP) else $error("deep sleep left on bad source");
   AST_STBY_SIX: assert property (@(posedge clk_sys) disable iff (rst) // R17
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_STBY && ext_crystal && wake_now
      |=> state_q == ST_WAKE [*6] ##1 state_q == ST_STALL) else $error("standby wake not six");
   AST_STALL4: assert property (@(posedge clk_sys) disable iff (rst) // R19
      $rose(state_q == ST_STALL) |-> state_q == ST_STALL [*4] ##1 state_q == ST_RUN)
      else $error("stall not four cycles");
   AST_EXT_IRQ0_PIN_GATE: assert property (@(posedge clk_sys) disable iff (rst) // R5
      !$past(global_irq_en) || !$past(ext_irq0_pin_mask) |-> !ext_irq0_pin_irq) else $error("ext_irq0_pin ungated");

   // ----------------------------------------------------------------
   // wake source and output checks
   // ----------------------------------------------------------------
   // the nop pass must never gate a clock, the core only loses one slot
   AST_NOP_CLK: assert property (@(posedge clk_sys) disable iff (rst) // R21
      state_q == ST_NOP |-> clk_en == 5'h1f) else $error("clock gated in nop");
   // conversion kick is judged from the mode actually entered
   AST_ADC_GO: assert property (@(posedge clk_sys) disable iff (rst) // R10
      $rose(state_q == ST_SLEEP) && !mode_q[1] && $past(adc_enabled) |-> adc_start)
      else $error("adc not started on sleep");
   AST_IDLE_WAKE: assert property (@(posedge clk_sys) disable iff (rst) // R9
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_IDLE && wake_src.other_io
      |=> state_q == ST_WAKE) else $error("idle missed io wake");
   AST_NR_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R12
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_ADCNR && !wake_src.adc_done
      && !wake_src.usi_start && !wake_src.ee_ready && !wake_src.pin_change && !lvl_irq
      |=> state_q == ST_SLEEP) else $error("noise reduction left on bad source");
   AST_EE_DEEP: assert property (@(posedge clk_sys) disable iff (rst) // R18
      state_q == ST_SLEEP && mode_q[1] && !wake_src.usi_start && !wake_src.pin_change
      && !lvl_irq && (wake_src.ee_ready || wake_src.adc_done || wake_src.other_io)
      |=> state_q == ST_SLEEP) else $error("deep sleep left on io source");
   AST_DROP_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // R16
      state_q == ST_STALL && drop_q |=> !ext_irq0_pin_irq) else $error("dropped cause executed");
   AST_STBY_OSC: assert property (@(posedge clk_sys) disable iff (rst) // R17
      state_q == ST_SLEEP && mode_q == smc_pkg::SMC_STBY && ext_crystal |-> clk_en.osc)
      else $error("standby oscillator stopped");
endmodule
`default_nettype wire

// ---- test/smc_cpu_model.sv ----
// smc_cpu_model.sv: behavioural cpu core and software driving the controller.
// assumes tasks are called just after a rising clk_sys edge.
`timescale 1ns/100ps
`default_nettype none
module smc_cpu_model (
   input wire logic clk_sys,
   input wire logic ack,
   input wire logic err,
   input wire logic [31:0] rdat,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [9:0] adr,
   output logic [31:0] wdat,
   output logic sleep_instr,
   output logic gie,
   output logic mask
);
   initial begin
      {cyc, stb, we, adr, wdat, sleep_instr, gie, mask} = '0;
   end
   // ----
   // bus cycle
   // ----
   // ends one idle cycle after release, so calls may follow back to back
   // request held until the edge that samples ack or err; only the bench watchdog ends a hang
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge clk_sys);
      while (ack !== 1'b1 && err !== 1'b1) begin
         @(posedge clk_sys);
      end
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask
   // arm just before the sleep instruction, never earlier
   task automatic do_sleep(input logic [1:0] mode, input logic arm);
      logic [31:0] q;
      logic e;
      bus(1'b1, 10'h0d4, {2'b00, arm, mode, 3'b000}, q, e);
      sleep_instr <= 1'b1;
      @(posedge clk_sys);
      sleep_instr <= 1'b0;
   endtask
   // mask first: a sense change could otherwise raise a stray request
   task automatic set_sense(input logic [1:0] s, input logic g);
      logic [31:0] q;
      logic e;
      mask <= 1'b0;
      gie <= g;
      bus(1'b1, 10'h0d4, {6'h00, s}, q, e);
      mask <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- test/sleep_mode_and_ext_irq0_pin_control_bench.sv ----
// sleep_mode_and_ext_irq0_pin_control_bench.sv: self-checking bench of smc_ctrl.
// assumes smc_pkg, smc_map.svh and the cpu model are compiled first.
`include "smc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_and_ext_irq0_pin_control_bench;
   typedef struct packed {
      logic [1:0] mode;
      logic [4:0] src;
      logic [4:0] clk;
      logic adc;
   } smc_row_t;
   // mode, wake source, running clocks, adc start expected
   smc_row_t rows [4] = '{'{2'h0, 5'h01, 5'h07, 1'b1}, '{2'h1, 5'h10, 5'h03, 1'b1},
                          '{2'h2, 5'h02, 5'h00, 1'b0}, '{2'h3, 5'h08, 5'h01, 1'b0}};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic pin = 1'b1;
   logic [3:0] su = 4'h1;
   logic [7:0] dir = 8'h0f;
   logic [7:0] outv = 8'hff;
   smc_pkg::smc_wake_t wake_src = '0;
   smc_pkg::smc_clk_t clk_en;
   logic cyc, stb, we, ack, err, sleep_instr, gie, mask, e;
   logic cpu_stall, sleep_done, adc_start, ext_irq0_pin_irq;
   logic [9:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [7:0] pullup_en;
   int error_cnt = 0;
   int comparisons = 0;
   int adc_cnt = 0;
   int irq_cnt = 0;
   int done_cnt = 0;
   int n, k;
   int dur [4];

   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (adc_start === 1'b1) adc_cnt++;
      if (ext_irq0_pin_irq === 1'b1) irq_cnt++;
      if (sleep_done === 1'b1) done_cnt++;
   end

   smc_cpu_model cpu (.clk_sys(clk_sys), .ack(ack), .err(err), .rdat(rdat), .cyc(cyc),
      .stb(stb), .we(we), .adr(adr), .wdat(wdat), .sleep_instr(sleep_instr), .gie(gie),
      .mask(mask));
   smc_ctrl uut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .sleep_instr(sleep_instr), .global_irq_en(gie),
      .ext_irq0_pin_mask(mask), .ext_irq0_pin(pin), .adc_enabled(1'b1), .ext_crystal(1'b1),
      .startup_select(su), .wake_src(wake_src), .pin_direction(dir),
      .pin_output_value(outv), .pullup_en(pullup_en), .clk_en(clk_en),
      .cpu_stall(cpu_stall), .sleep_done(sleep_done), .adc_start(adc_start),
      .ext_irq0_pin_irq(ext_irq0_pin_irq), .wake_irq_drop());

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({cpu_stall, clk_en}, 6'h1f);
      cpu.bus(1'b0, `SMC_GENCTL_ADDR, 8'h00, q, e);
      chk(q, `SMC_GENCTL_RST);
      cpu.bus(1'b1, `SMC_GENCTL_ADDR, 8'hff, q, e);
      cpu.bus(1'b0, `SMC_GENCTL_ADDR, 8'h00, q, e);
      chk(q, 8'h7b);
      chk(pullup_en, 8'h00);
      cpu.bus(1'b1, `SMC_GENCTL_ADDR, 8'h00, q, e);
      chk(pullup_en, 8'hf0);
      cpu.bus(1'b0, 10'h3fc, 8'h00, q, e);
      chk({e, q[30:0]}, 32'h80000000);
      // ----
      // unarmed sleep falls through
      // ----
      n = done_cnt;
      cpu.do_sleep(2'h2, 1'b0);
      @(negedge clk_sys);
      chk({cpu_stall, clk_en}, 6'h3f);
      repeat (3) @(posedge clk_sys);
      chk(done_cnt - n, 1);
      // ----
      // one row per sleep mode
      // ----
      for (int i = 0; i < 4; i++) begin
         n = adc_cnt;
         cpu.do_sleep(rows[i].mode, 1'b1);
         @(negedge clk_sys);
         chk({cpu_stall, clk_en}, {1'b1, rows[i].clk});
         @(posedge clk_sys);
         wake_src <= rows[i].src;
         k = 0;
         while (cpu_stall !== 1'b0 && k < 400) begin
            @(negedge clk_sys);
            k++;
         end
         dur[i] = k;
         chk(clk_en, 5'h1f);
         chk(adc_cnt - n, rows[i].adc);
         @(posedge clk_sys);
         wake_src <= '0;
         @(posedge clk_sys);
      end
      chk(dur[3] - dur[0], 5);
      chk(dur[2] - dur[0], 16 * su);
      // eeprom and adc events must not end power-down
      cpu.do_sleep(2'h2, 1'b1);
      wake_src <= 5'h15;
      repeat (40) @(posedge clk_sys);
      chk(cpu_stall, 1);
      // a reset in sleep restarts with defaults
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wake_src <= '0;
      @(posedge clk_sys);
      chk({cpu_stall, clk_en}, 6'h1f);
      // ----
      // interrupt 0 sense modes, sense written only while masked
      // ----
      for (int s = 0; s < 4; s++) begin
         pin <= ~s[0];
         repeat (4) @(posedge clk_sys);
         cpu.set_sense(s[1:0], 1'b1);
         n = irq_cnt;
         pin <= s[0];
         repeat (8) @(posedge clk_sys);
         chk(irq_cnt != n, 1);
      end
      cpu.set_sense(2'h0, 1'b0);
      n = irq_cnt;
      pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk(irq_cnt - n, 0);
      finish_test();
   end
endmodule
`default_nettype wire
